// ---- verilog/pimc_pkg.sv ----
// shared constants for the port ingress acl / mirror / priority control block
package pimc_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFF_ACL_CTRL = 16'h1612;
  localparam logic [15:0] OFF_BYTE_EN_MSB = 16'h1610;
  localparam logic [15:0] OFF_BYTE_EN_LSB = 16'h1611;
  localparam logic [15:0] OFF_MIRROR = 16'h1800;
  localparam logic [15:0] OFF_PRIO_SEL = 16'h1801;
  localparam logic [15:0] OFF_DEF_PRIO = 16'h1802;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ACL_WR_DONE_BIT = 6;
  localparam int ACL_RD_DONE_BIT = 5;
  localparam int ACL_DIR_BIT = 4;
  localparam int ACL_IDX_MSB = 3;
  localparam int MIR_RX_BIT = 6;
  localparam int MIR_TX_BIT = 5;
  localparam int MIR_SNIFF_BIT = 1;
  localparam int PR_HIGHEST_BIT = 7;
  localparam int PR_OR_BIT = 6;
  localparam int PR_MAC_BIT = 4;
  localparam int PR_VLAN_BIT = 3;
  localparam int PR_DOT1P_BIT = 2;
  localparam int PR_DSCP_BIT = 1;
  localparam int PR_ACL_BIT = 0;
  localparam int DEF_PRIO_MSB = 2;
  // ****************************************
  // masks and resets
  // ****************************************
  localparam logic [7:0] MIR_RW_MASK = 8'h62;
  localparam logic [7:0] PRIO_RW_MASK = 8'hdf;
  localparam logic [7:0] DEF_PRIO_MASK = 8'h07;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] ACL_CTRL_RW_RST = 5'h00;
  localparam logic ACL_DONE_RST = 1'b1;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int ACL_ACCESS_NS = 16;
  localparam int ACL_ACCESS_CYC = (ACL_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] ACL_CYC = 4'(ACL_ACCESS_CYC);
  typedef enum logic [1:0] {PIMC_IDLE, PIMC_BUSY} pimc_acl_e;
endpackage

// ---- verilog/pimc_acl_seq.sv ----
// acl table access sequencer: completion status per direction
`timescale 1ns/100ps
module pimc_acl_seq
  import pimc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // launch
  input wire logic launch,
  input wire logic launch_wr,
  input wire logic [15:0] launch_be,
  input wire logic [3:0] launch_idx,
  // table port
  output logic tbl_req,
  output logic tbl_wr,
  output logic [3:0] tbl_idx,
  output logic [15:0] tbl_be,
  // status
  output logic wr_done,
  output logic rd_done
);
  import pimc_pkg::*;
  // ****************************************
  // sequencer
  // ****************************************
  pimc_acl_e st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic [3:0] idx_reg, idx_next;
  logic [15:0] be_reg, be_next;
  logic wd_reg, wd_next;
  logic rd_reg, rd_next;
  logic req_reg, req_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    idx_next = idx_reg;
    be_next = be_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    req_next = 1'b0;
    case (st_reg)
      PIMC_IDLE: begin
        if (launch) begin
          // relaunch while busy is ignored: entry would be half moved
          st_next = PIMC_BUSY;
          cnt_next = ACL_CYC;
          wr_next = launch_wr;
          idx_next = launch_idx;
          be_next = launch_be; // RQ17
          req_next = 1'b1;
          if (launch_wr) begin
            wd_next = 1'b0; // RQ19
          end else begin
            rd_next = 1'b0; // RQ19
          end
        end
      end
      PIMC_BUSY: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          st_next = PIMC_IDLE;
          if (wr_reg) begin
            wd_next = 1'b1; // RQ1
          end else begin
            rd_next = 1'b1; // RQ2
          end
        end
      end
      default: st_next = PIMC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg <= PIMC_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      idx_reg <= 4'h0;
      be_reg <= 16'h0000;
      wd_reg <= ACL_DONE_RST;
      rd_reg <= ACL_DONE_RST;
      req_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      idx_reg <= idx_next;
      be_reg <= be_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      req_reg <= req_next;
    end
  end

  assign tbl_req = req_reg;
  assign tbl_wr = wr_reg;
  assign tbl_idx = idx_reg;
  assign tbl_be = be_reg;
  assign wr_done = wd_reg;
  assign rd_done = rd_reg;

  done_after_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
    (st_reg == PIMC_IDLE && launch && launch_wr) |=> !wd_reg [*4] ##1 wd_reg)
    else $error("write status timing wrong");
  rd_clear_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
    (st_reg == PIMC_IDLE && launch && !launch_wr) |=> !rd_reg [*4] ##1 rd_reg)
    else $error("read status not cleared then set");
endmodule

// ---- verilog/pimc_prio_sel.sv ----
// ingress priority resolver for one port
`timescale 1ns/100ps
module pimc_prio_sel
  import pimc_pkg::*;
(
  // control
  input wire logic [7:0] sel,
  input wire logic [2:0] def_prio,
  // candidate priorities with their valid flags
  input wire logic mac_vld,
  input wire logic [2:0] mac_prio,
  input wire logic vlan_vld,
  input wire logic [2:0] vlan_prio,
  input wire logic dot1p_vld,
  input wire logic [2:0] dot1p_prio,
  input wire logic dscp_vld,
  input wire logic [2:0] dscp_prio,
  input wire logic acl_vld,
  input wire logic [2:0] acl_prio,
  // result
  output logic [2:0] prio
);
  import pimc_pkg::*;

  function automatic logic [2:0] gate(input logic en, input logic v,
                                       input logic [2:0] p);
    gate = (en && v) ? p : 3'h0;
  endfunction

  logic [2:0] m, vl, d1, ds, ac, orv, hi;
  logic any;

  always_comb begin
    m = gate(sel[PR_MAC_BIT], mac_vld, mac_prio); // RQ12
    vl = gate(sel[PR_VLAN_BIT], vlan_vld, vlan_prio); // RQ13
    d1 = gate(sel[PR_DOT1P_BIT], dot1p_vld, dot1p_prio); // RQ14
    ds = gate(sel[PR_DSCP_BIT], dscp_vld, dscp_prio); // RQ15
    ac = gate(sel[PR_ACL_BIT], acl_vld, acl_prio); // RQ16
    any = (sel[PR_MAC_BIT] && mac_vld) || (sel[PR_VLAN_BIT] && vlan_vld) ||
          (sel[PR_DOT1P_BIT] && dot1p_vld) ||
          (sel[PR_DSCP_BIT] && dscp_vld) || (sel[PR_ACL_BIT] && acl_vld);
    // without a per-method enable the combiners see every valid result
    if (sel[PR_HIGHEST_BIT] || sel[PR_OR_BIT]) begin
      m = gate(1'b1, mac_vld, mac_prio);
      vl = gate(1'b1, vlan_vld, vlan_prio);
      d1 = gate(1'b1, dot1p_vld, dot1p_prio);
      ds = gate(1'b1, dscp_vld, dscp_prio);
      ac = gate(1'b1, acl_vld, acl_prio);
      any = mac_vld || vlan_vld || dot1p_vld || dscp_vld || acl_vld;
    end
    orv = m | vl | d1 | ds | ac; // RQ11
    hi = m;
    if (vl > hi) hi = vl; // RQ10
    if (d1 > hi) hi = d1;
    if (ds > hi) hi = ds;
    if (ac > hi) hi = ac;
    if (!any) begin
      prio = def_prio; // RQ18
    end else if (sel[PR_HIGHEST_BIT]) begin
      prio = hi; // RQ10
    end else if (sel[PR_OR_BIT]) begin
      prio = orv; // RQ11
    end else begin
      // several enables set is misuse; or-ing keeps a defined answer
      prio = orv;
    end
  end
endmodule

// ---- verilog/pimc_port_ctrl.sv ----
// per-port ingress control: acl access, mirroring and priority select
// Functional notes
// [RQ1] write status bit 6, resets to one
// [RQ2] read status bit 5, resets to one
// [RQ3] software polls read status before results
// [RQ4] direction bit 4, entry index bits 3:0
// [RQ5] receive monitoring marks and mirrors rx packets
// [RQ6] transmit monitoring marks and mirrors tx packets
// [RQ7] sniffer bit makes port send monitored packets
// [RQ8] software also sets global mirroring setup
// [RQ9] software sets one priority bit at most
// [RQ10] bit 7 picks highest priority result
// [RQ11] bit 6 ors all priority results
// [RQ12] bit 4 enables mac priority classification
// [RQ13] bit 3 enables vlan priority classification
// [RQ14] bit 2 enables 802.1p priority classification
// [RQ15] bit 1 enables diffserv priority classification
// [RQ16] bit 0 enables acl priority classification
// [RQ17] byte-enable low write launches table access
// [RQ18] no result gives port default priority
// [RQ19] launch clears status, completion sets it
`timescale 1ns/100ps
module pimc_port_ctrl
  import pimc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [pimc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // acl table port
  output logic tbl_req,
  output logic tbl_wr,
  output logic [3:0] tbl_idx,
  output logic [15:0] tbl_be,
  // mirroring
  input wire logic rx_pkt,
  input wire logic tx_pkt,
  input wire logic mon_pkt_in,
  output logic rx_mon,
  output logic tx_mon,
  output logic sniff_tx,
  // classification inputs
  input wire logic mac_vld,
  input wire logic [2:0] mac_prio,
  input wire logic vlan_vld,
  input wire logic [2:0] vlan_prio,
  input wire logic dot1p_vld,
  input wire logic [2:0] dot1p_prio,
  input wire logic dscp_vld,
  input wire logic [2:0] dscp_prio,
  input wire logic acl_vld,
  input wire logic [2:0] acl_prio,
  // classification result
  output logic [2:0] ingress_prio
);
  import pimc_pkg::*;

  // ****************************************
  // register file
  // ****************************************
  logic [4:0] acl_ctrl_reg, acl_ctrl_next;
  logic [7:0] be_msb_reg, be_msb_next;
  logic [7:0] be_lsb_reg, be_lsb_next;
  logic [7:0] mir_reg, mir_next;
  logic [7:0] prio_reg, prio_next;
  logic [7:0] defp_reg, defp_next;
  logic [7:0] rdata_reg, rdata_next;
  logic launch;
  logic wr_done, rd_done;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
    hit = (a == o);
  endfunction

  always_comb begin
    acl_ctrl_next = acl_ctrl_reg;
    be_msb_next = be_msb_reg;
    be_lsb_next = be_lsb_reg;
    mir_next = mir_reg;
    prio_next = prio_reg;
    defp_next = defp_reg;
    launch = 1'b0;
    if (reg_wr) begin
      if (hit(reg_addr, OFF_ACL_CTRL)) begin
        acl_ctrl_next = reg_wdata[ACL_DIR_BIT:0]; // RQ4
      end
      if (hit(reg_addr, OFF_BYTE_EN_MSB)) begin
        be_msb_next = reg_wdata;
      end
      if (hit(reg_addr, OFF_BYTE_EN_LSB)) begin
        be_lsb_next = reg_wdata;
        launch = 1'b1; // RQ17
      end
      if (hit(reg_addr, OFF_MIRROR)) begin
        mir_next = reg_wdata & MIR_RW_MASK;
      end
      if (hit(reg_addr, OFF_PRIO_SEL)) begin
        prio_next = reg_wdata & PRIO_RW_MASK;
      end
      if (hit(reg_addr, OFF_DEF_PRIO)) begin
        defp_next = reg_wdata & DEF_PRIO_MASK;
      end
    end
    // unmapped reads return zero
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, OFF_ACL_CTRL)) begin
        rdata_next = {1'b0, wr_done, rd_done, acl_ctrl_reg}; // RQ1 RQ2
      end
      if (hit(reg_addr, OFF_BYTE_EN_MSB)) begin
        rdata_next = be_msb_reg;
      end
      if (hit(reg_addr, OFF_BYTE_EN_LSB)) begin
        rdata_next = be_lsb_reg;
      end
      if (hit(reg_addr, OFF_MIRROR)) begin
        rdata_next = mir_reg;
      end
      if (hit(reg_addr, OFF_PRIO_SEL)) begin
        rdata_next = prio_reg;
      end
      if (hit(reg_addr, OFF_DEF_PRIO)) begin
        rdata_next = defp_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acl_ctrl_reg <= ACL_CTRL_RW_RST;
      be_msb_reg <= BYTE_RST;
      be_lsb_reg <= BYTE_RST;
      mir_reg <= BYTE_RST;
      prio_reg <= BYTE_RST;
      defp_reg <= BYTE_RST;
      rdata_reg <= BYTE_RST;
    end else begin
      acl_ctrl_reg <= acl_ctrl_next;
      be_msb_reg <= be_msb_next;
      be_lsb_reg <= be_lsb_next;
      mir_reg <= mir_next;
      prio_reg <= prio_next;
      defp_reg <= defp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************
  // acl access sequencer
  // ****************************************
  // direction and index are the stored control; write it before launch
  pimc_acl_seq u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .launch(launch),
    .launch_wr(acl_ctrl_reg[ACL_DIR_BIT]),
    .launch_be({be_msb_reg, be_lsb_next}),
    .launch_idx(acl_ctrl_reg[ACL_IDX_MSB:0]),
    .tbl_req(tbl_req),
    .tbl_wr(tbl_wr),
    .tbl_idx(tbl_idx),
    .tbl_be(tbl_be),
    .wr_done(wr_done),
    .rd_done(rd_done)
  );

  // ****************************************
  // mirroring
  // ****************************************
  logic rx_mon_reg, rx_mon_next;
  logic tx_mon_reg, tx_mon_next;
  logic sniff_reg, sniff_next;

  // global mirroring setup lives elsewhere; only per-port marks here
  always_comb begin
    rx_mon_next = rx_pkt && mir_reg[MIR_RX_BIT]; // RQ5
    tx_mon_next = tx_pkt && mir_reg[MIR_TX_BIT]; // RQ6
    sniff_next = mon_pkt_in && mir_reg[MIR_SNIFF_BIT]; // RQ7
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_mon_reg <= 1'b0;
      tx_mon_reg <= 1'b0;
      sniff_reg <= 1'b0;
    end else begin
      rx_mon_reg <= rx_mon_next;
      tx_mon_reg <= tx_mon_next;
      sniff_reg <= sniff_next;
    end
  end

  assign rx_mon = rx_mon_reg;
  assign tx_mon = tx_mon_reg;
  assign sniff_tx = sniff_reg;

  // ****************************************
  // priority classification
  // ****************************************
  logic [2:0] prio_out_next;
  logic [2:0] prio_out_reg;

  pimc_prio_sel u_prio (
    .sel(prio_reg),
    .def_prio(defp_reg[DEF_PRIO_MSB:0]),
    .mac_vld(mac_vld),
    .mac_prio(mac_prio),
    .vlan_vld(vlan_vld),
    .vlan_prio(vlan_prio),
    .dot1p_vld(dot1p_vld),
    .dot1p_prio(dot1p_prio),
    .dscp_vld(dscp_vld),
    .dscp_prio(dscp_prio),
    .acl_vld(acl_vld),
    .acl_prio(acl_prio),
    .prio(prio_out_next)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prio_out_reg <= 3'h0;
    end else begin
      prio_out_reg <= prio_out_next;
    end
  end

  assign ingress_prio = prio_out_reg;

  // ****************************************
  // checks
  // ****************************************
  rx_mirror_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
    (rx_pkt && mir_reg[MIR_RX_BIT]) |=> rx_mon)
    else $error("rx packet not monitored");
  rx_cause_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ5
    rx_mon |-> $past(rx_pkt) && $past(mir_reg[MIR_RX_BIT]))
    else $error("rx monitor without cause");
  tx_mirror_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
    tx_mon |-> $past(tx_pkt) && $past(mir_reg[MIR_TX_BIT]))
    else $error("tx monitor without cause");
  sniffer_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
    (mon_pkt_in && mir_reg[MIR_SNIFF_BIT]) |=> sniff_tx)
    else $error("sniffer port did not send");
  sniff_cause_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
    sniff_tx |-> $past(mon_pkt_in) && $past(mir_reg[MIR_SNIFF_BIT]))
    else $error("sniffer sent without cause");
  default_prio_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ18
    (!mac_vld && !vlan_vld && !dot1p_vld && !dscp_vld && !acl_vld)
    |=> ingress_prio == $past(defp_reg[DEF_PRIO_MSB:0]))
    else $error("default priority not applied");
  default_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ18
    prio_reg == 8'h00 |=> ingress_prio == $past(defp_reg[DEF_PRIO_MSB:0]))
    else $error("no method enabled yet default not used");
  highest_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ10
    (prio_reg == 8'h80 && mac_vld && vlan_vld && acl_vld)
    |=> ingress_prio >= $past(mac_prio) &&
    ingress_prio >= $past(vlan_prio) && ingress_prio >= $past(acl_prio) &&
    (ingress_prio == $past(mac_prio) || ingress_prio == $past(vlan_prio) ||
     ingress_prio == $past(acl_prio) || ingress_prio == $past(dscp_prio) ||
     ingress_prio == $past(dot1p_prio)))
    else $error("highest priority not chosen");
  or_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ11
    (prio_reg == 8'h40 && mac_vld && vlan_vld && dot1p_vld && dscp_vld &&
     acl_vld)
    |=> ingress_prio == $past(mac_prio | vlan_prio | dot1p_prio |
    dscp_prio | acl_prio))
    else $error("combined_priority_sel wrong");
  mac_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ12
    (prio_reg == 8'h10 && mac_vld) |=> ingress_prio == $past(mac_prio))
    else $error("mac priority not applied");
  vlan_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ13
    (prio_reg == 8'h08 && vlan_vld) |=> ingress_prio == $past(vlan_prio))
    else $error("vlan priority not applied");
  dot1p_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ14
    (prio_reg == 8'h04 && dot1p_vld) |=> ingress_prio == $past(dot1p_prio))
    else $error("802.1p priority not applied");
  dscp_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ15
    (prio_reg == 8'h02 && dscp_vld) |=> ingress_prio == $past(dscp_prio))
    else $error("diffserv priority not applied");
  acl_sel_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ16
    (prio_reg == 8'h01 && acl_vld) |=> ingress_prio == $past(acl_prio))
    else $error("acl priority not applied");
  launch_req_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ17
    (reg_wr && reg_addr == OFF_BYTE_EN_LSB && wr_done && rd_done)
    |=> tbl_req && tbl_be[7:0] == $past(reg_wdata))
    else $error("byte enable write did not launch");
  launch_busy_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ17
    (reg_wr && reg_addr == OFF_BYTE_EN_LSB && !(wr_done && rd_done))
    |=> !tbl_req)
    else $error("launch taken while busy");
  dir_field_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ4
    (reg_wr && reg_addr == OFF_ACL_CTRL) |=> acl_ctrl_reg ==
    $past(reg_wdata[ACL_DIR_BIT:0]))
    else $error("direction or index not stored");
  status_read_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
    (reg_rd && reg_addr == OFF_ACL_CTRL)
    |=> reg_rdata[ACL_WR_DONE_BIT] == $past(wr_done) &&
    reg_rdata[ACL_RD_DONE_BIT] == $past(rd_done))
    else $error("status bits not read back");
endmodule

// ---- testbench/port_ingress_acl_mirror_priority_ctrl_tb.sv ----
// self-checking bench for the per-port ingress control block
`timescale 1ns/100ps
module port_ingress_acl_mirror_priority_ctrl_tb;
  import pimc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tbl_req, tbl_wr;
  logic [3:0] tbl_idx;
  logic [15:0] tbl_be;
  logic rx_pkt = 1'b0, tx_pkt = 1'b0, mon_pkt_in = 1'b0;
  logic rx_mon, tx_mon, sniff_tx;
  // valid flags in select-bit order: mac vlan dot1p dscp acl
  logic [4:0] vld = 5'h00;
  logic [2:0] p_mac = 3'h1, p_vlan = 3'h4, p_dot1p = 3'h5;
  logic [2:0] p_dscp = 3'h2, p_acl = 3'h6;
  logic [2:0] ingress_prio;
  int err_count = 0;
  int checks = 0;
  logic [15:0] ta [7] = '{16'h1612, 16'h1800, 16'h1801, 16'h1802,
                          16'h1610, 16'h1700, 16'h1611};
  logic [7:0] we [6] = '{8'h7f, 8'h62, 8'hdf, 8'h07, 8'hff, 8'h00};
  logic [7:0] ms [5] = '{8'h40, 8'h20, 8'h02, 8'h00, 8'h62};
  logic [7:0] ps [8] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h80,
                         8'h40, 8'h00};
  logic [2:0] pe [8] = '{3'h1, 3'h4, 3'h5, 3'h2, 3'h6, 3'h6, 3'h7, 3'h3};
  logic [7:0] d;
  logic [2:0] e;

  always #2 clk_sys = ~clk_sys;

  pimc_port_ctrl pimc_port_ctrl_inst (
    .clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tbl_req(tbl_req), .tbl_wr(tbl_wr), .tbl_idx(tbl_idx),
    .tbl_be(tbl_be),
    .rx_pkt(rx_pkt), .tx_pkt(tx_pkt), .mon_pkt_in(mon_pkt_in),
    .rx_mon(rx_mon), .tx_mon(tx_mon), .sniff_tx(sniff_tx),
    .mac_vld(vld[4]), .mac_prio(p_mac), .vlan_vld(vld[3]),
    .vlan_prio(p_vlan), .dot1p_vld(vld[2]), .dot1p_prio(p_dot1p),
    .dscp_vld(vld[1]), .dscp_prio(p_dscp), .acl_vld(vld[0]),
    .acl_prio(p_acl), .ingress_prio(ingress_prio)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // strobe stands one cycle; caller resumes 1ns after the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic reset_table;
    logic [7:0] v;
    for (int i = 0; i < 7; i++) begin
      rd(ta[i], v);
      chk("reset", {8'h00, (i == 0) ? 8'h60 : 8'h00}, {8'h00, v});
    end
  endtask

  // launch, refused relaunch while busy, then poll for completion
  task automatic acl_run(input logic [7:0] ctl, input logic [7:0] lsb,
                         input logic [15:0] be);
    logic [7:0] v;
    logic [7:0] busy;
    int n;
    int sb;
    sb = ctl[4] ? 6 : 5;
    busy = (ctl[4] ? 8'h20 : 8'h40) | {3'h0, ctl[4:0]};
    wr(OFF_ACL_CTRL, ctl);
    wr(OFF_BYTE_EN_LSB, lsb);
    chk("tbl_req launch", 16'h0001, {15'h0, tbl_req});
    chk("tbl_wr", {15'h0, ctl[4]}, {15'h0, tbl_wr});
    chk("tbl_idx", {12'h0, ctl[3:0]}, {12'h0, tbl_idx});
    chk("tbl_be", be, tbl_be);
    rd(OFF_ACL_CTRL, v);
    chk("acl ctrl busy", {8'h00, busy}, {8'h00, v});
    chk("tbl_req pulse", 16'h0000, {15'h0, tbl_req});
    wr(OFF_BYTE_EN_LSB, ~lsb);
    chk("tbl_req refused", 16'h0000, {15'h0, tbl_req});
    chk("tbl_be held", be, tbl_be);
    n = 0;
    // results are only trusted once the status bit is back
    do begin
      rd(OFF_ACL_CTRL, v);
      n++;
    end while (v[sb] !== 1'b1 && n < 8);
    chk("acl ctrl done", {11'h003, ctl[4:0]}, {8'h00, v});
    chk("poll count", 16'h0003, 16'(n));
    @(posedge clk_sys);
    #1;
    chk("rdata drops", 16'h0000, {8'h00, reg_rdata});
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial begin
    #20000;
    err_count++;
    $display("BAD watchdog expected finish seen timeout");
    conclude();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("tbl_req rst", 16'h0000, {15'h0, tbl_req});
    chk("tbl_be rst", 16'h0000, tbl_be);
    chk("mon rst", 16'h0000, {13'h0, rx_mon, tx_mon, sniff_tx});
    chk("prio rst", 16'h0000, {13'h0, ingress_prio});
    chk("rdata rst", 16'h0000, {8'h00, reg_rdata});
    @(posedge clk_sys);
    #1;
    reset_table();
    $display("test reset values done");

    // reserved and status bits ignore writes; unmapped stays zero
    for (int i = 0; i < 6; i++) wr(ta[i], 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(ta[i], d);
      chk("masked readback", {8'h00, we[i]}, {8'h00, d});
    end
    for (int i = 0; i < 6; i++) wr(ta[i], 8'h00);
    $display("test register access done");

    wr(OFF_BYTE_EN_MSB, 8'h5a);
    acl_run(8'h1a, 8'hc3, 16'h5ac3);
    acl_run(8'h03, 8'h81, 16'h5a81);
    $display("test acl access done");

    for (int i = 0; i < 5; i++) begin
      wr(OFF_MIRROR, ms[i]);
      rx_pkt <= 1'b1;
      tx_pkt <= 1'b1;
      // offered monitored packets stand for the global mirroring setup
      mon_pkt_in <= 1'b1;
      @(posedge clk_sys);
      rx_pkt <= 1'b0;
      tx_pkt <= 1'b0;
      mon_pkt_in <= 1'b0;
      #1;
      chk("rx_mon", {15'h0, ms[i][6]}, {15'h0, rx_mon});
      chk("tx_mon", {15'h0, ms[i][5]}, {15'h0, tx_mon});
      chk("sniff_tx", {15'h0, ms[i][1]}, {15'h0, sniff_tx});
      @(posedge clk_sys);
      #1;
      chk("idle", 16'h0, {13'h0, rx_mon, tx_mon, sniff_tx});
    end
    $display("test mirroring done");

    wr(OFF_DEF_PRIO, 8'h03);
    for (int p = 0; p < 2; p++) begin
      vld <= (p == 0) ? 5'h1f : 5'h00;
      for (int i = 0; i < 8; i++) begin
        wr(OFF_PRIO_SEL, ps[i]);
        @(posedge clk_sys);
        #1;
        e = (p == 0) ? pe[i] : 3'h3;
        chk("prio", {13'h0, e}, {13'h0, ingress_prio});
      end
    end
    $display("test priority select done");

    // second reset in mid-run with registers dirty and an access busy
    wr(OFF_MIRROR, 8'h62);
    wr(OFF_BYTE_EN_LSB, 8'h01);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("tbl_be rst", 16'h0000, tbl_be);
    reset_table();
    $display("test second reset done");
    conclude();
  end
endmodule
